//--- common/pss_map.vh
// Purpose: constants for the power startup state machine
// Assumes: 40 MHz system clock
// Notes:
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
`define PSS_MODE_OFF      2'b00
`define PSS_MODE_PWM      2'b01
`define PSS_MODE_AUTOSKIP 2'b11
`define PSS_CLK_HZ        40000000
`define PSS_RETRY_US      2000
`define PSS_RETRY_CYC     ((`PSS_RETRY_US * (`PSS_CLK_HZ / 1000000)))
`define PSS_SELFTEST_MAX  2'd3
`define PSS_STEP_CYC      16
`define PSS_LOAD_WAIT     8
`endif

//--- verilog/pss_selftest.v
// Purpose: self test sequencer with retries
// Assumes: test results arrive as levels with a done strobe
// Notes: monitor test only reports
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_selftest #(
    parameter RETRY_CYC = `PSS_RETRY_CYC
) (
    input  wire       clk_sys_i,
    input  wire       resetn_i,
    input  wire       start_i,
    input  wire       test_done_i,
    input  wire       clk_ok_i,
    input  wire       bandgap_ok_i,
    input  wire       crc_ok_i,
    input  wire       monitor_ok_i,
    output reg        run_test_o,
    output reg        pass_o,
    output reg        fail_o,
    output reg        monitor_flag_o
);
    localparam S_IDLE = 2'd0;
    localparam S_TEST = 2'd1;
    localparam S_WAIT = 2'd2;
    reg [1:0]  state_r;
    reg [1:0]  tries_r;
    reg [31:0] wait_r;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r        <= S_IDLE;
            tries_r        <= 2'd0;
            wait_r         <= 32'h0000_0000;
            run_test_o     <= 1'b0;
            pass_o         <= 1'b0;
            fail_o         <= 1'b0;
            monitor_flag_o <= 1'b0;
        end else begin
            pass_o <= 1'b0;
            fail_o <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start_i) begin
                        state_r    <= S_TEST;
                        tries_r    <= 2'd1;
                        run_test_o <= 1'b1;
                    end
                end
                S_TEST: begin
                    if (test_done_i) begin
                        run_test_o <= 1'b0;
                        if (!monitor_ok_i)
                            monitor_flag_o <= 1'b1;
                        if (clk_ok_i && bandgap_ok_i && crc_ok_i) begin
                            pass_o  <= 1'b1;
                            state_r <= S_IDLE;
                        end else if (tries_r == `PSS_SELFTEST_MAX) begin
                            fail_o  <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            wait_r  <= RETRY_CYC - 1;
                            state_r <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (wait_r == 32'h0000_0000) begin
                        tries_r    <= tries_r + 2'd1;
                        run_test_o <= 1'b1;
                        state_r    <= S_TEST;
                    end else begin
                        wait_r <= wait_r - 32'h0000_0001;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- verilog/pss_defaults.v
// Purpose: power-up default values from fuse fields
// Assumes: fuse inputs stable when load strobe arrives
// Notes: combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_defaults #(
    parameter NSW = 2
) (
    input  wire [NSW-1:0]   sw_in_seq_i,
    input  wire             fuse_sync_mode_i,
    input  wire             fuse_sync_output_enable_i,
    input  wire             fuse_spread_spectrum_enable_i,
    input  wire [NSW-1:0]   fuse_switch_mode_i,
    output reg  [2*NSW-1:0] switcher_run_mode_o
);
    integer i;
    reg     force_pwm;
    always @* begin
        force_pwm = fuse_sync_mode_i || fuse_sync_output_enable_i || fuse_spread_spectrum_enable_i;
        switcher_run_mode_o = {2*NSW{1'b0}};
        for (i = 0; i < NSW; i = i + 1) begin
            if (!sw_in_seq_i[i])
                switcher_run_mode_o[2*i +: 2] = `PSS_MODE_OFF;
            else if (force_pwm)
                switcher_run_mode_o[2*i +: 2] = `PSS_MODE_PWM;
            else if (fuse_switch_mode_i[i])
                switcher_run_mode_o[2*i +: 2] = `PSS_MODE_PWM;
            else
                switcher_run_mode_o[2*i +: 2] = `PSS_MODE_AUTOSKIP;
        end
    end
endmodule
`default_nettype wire

//--- verilog/pss_startup.v
// Purpose: top power state machine from supply to run
// Assumes: inputs synchronous to clk_sys_i
// Notes: sequence slots are 0..NSTEP-1; host reset in slot reset_slot_i
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_startup #(
    parameter NSW       = 2,
    parameter NLDO      = 1,
    parameter NSTEP     = 4,
    parameter RETRY_CYC = `PSS_RETRY_CYC
) (
    input  wire              clk_sys_i,
    input  wire              resetn_i,
    input  wire              core_digital_ldo_ok_i,
    input  wire              core_analog_ldo_ok_i,
    input  wire              fuse_select_pin_i,
    input  wire              load_done_i,
    input  wire              trim_crc_ok_i,
    input  wire              fuse_crc_ok_i,
    input  wire              uv_crossing_i,
    input  wire              lpm_set_i,
    input  wire              lpm_value_i,
    input  wire              powerup_event_i,
    input  wire              io_supply_ok_i,
    input  wire              test_done_i,
    input  wire              clk_ok_i,
    input  wire              bandgap_ok_i,
    input  wire              mirror_crc_ok_i,
    input  wire              monitor_ok_i,
    input  wire [NSW-1:0]    sw_in_seq_i,
    input  wire [NLDO-1:0]   ldo_in_seq_i,
    input  wire [2*NSW-1:0]  sw_slot_i,
    input  wire [2*NLDO-1:0] ldo_slot_i,
    input  wire [1:0]        reset_slot_i,
    input  wire              fuse_sync_mode_i,
    input  wire              fuse_sync_output_enable_i,
    input  wire              fuse_spread_spectrum_enable_i,
    input  wire [NSW-1:0]    fuse_switch_mode_i,
    input  wire [8*NSW-1:0]  fuse_switcher_voltage_i,
    input  wire [4*NLDO-1:0] fuse_linear_voltage_i,
    input  wire [4:0]        fuse_aux_voltage_i,
    input  wire              fuse_backup_cfg_i,
    input  wire              host_wr_i,
    input  wire [8*NSW-1:0]  host_sw_voltage_i,
    input  wire [4*NLDO-1:0] host_ldo_voltage_i,
    input  wire [NLDO-1:0]   host_ldo_enable_i,
    output reg  [2:0]        state_o,
    output reg               fuse_load_o,
    output reg               mirror_to_func_o,
    output reg               trim_load_error_o,
    output reg               fuse_load_error_o,
    output reg               selftest_error_o,
    output reg               monitor_test_flag_o,
    output reg               run_test_o,
    output reg               backup_supply_en_o,
    output reg               backup_supply_cfg_o,
    output reg               low_power_off_select_o,
    output reg               mirror_access_o,
    output reg               func_access_o,
    output reg               fail_safe_o,
    output reg  [NSW-1:0]    sw_enable_o,
    output reg  [NLDO-1:0]   ldo_enable_o,
    output reg               host_reset_out_o,
    output reg  [8*NSW-1:0]  switcher_run_voltage_o,
    output reg  [4*NLDO-1:0] linear_run_voltage_o,
    output reg  [4:0]        aux_switcher_voltage_o,
    output reg  [2*NSW-1:0]  switcher_run_mode_o,
    output reg  [NLDO-1:0]   linear_run_enable_o
);
    // =====================================================
    // states
    localparam ST_LOAD  = 3'd0;
    localparam ST_LPOFF = 3'd1;
    localparam ST_TEST  = 3'd2;
    localparam ST_QPU   = 3'd3;
    localparam ST_PWRUP = 3'd4;
    localparam ST_RUN   = 3'd5;
    localparam ST_FAIL  = 3'd6;

    reg  [2:0]       state_r;
    reg  [1:0]       slot_r;
    reg  [4:0]       step_cnt_r;
    reg              pwrup_done_r;
    wire             st_pass;
    wire             st_fail;
    wire             st_run;
    wire             st_flag;
    wire [2*NSW-1:0] mode_dflt;
    wire             any_error;
    integer          k;

    assign any_error = trim_load_error_o | fuse_load_error_o | selftest_error_o;

    // =====================================================
    // helpers
    pss_selftest #(
        .RETRY_CYC (RETRY_CYC)
    ) u_selftest (
        .clk_sys_i      (clk_sys_i),
        .resetn_i       (resetn_i),
        .start_i        (state_r == ST_LPOFF && powerup_event_i && !lpm_flag_blocked(1'b0)),
        .test_done_i    (test_done_i),
        .clk_ok_i       (clk_ok_i),
        .bandgap_ok_i   (bandgap_ok_i),
        .crc_ok_i       (mirror_crc_ok_i),
        .monitor_ok_i   (monitor_ok_i),
        .run_test_o     (st_run),
        .pass_o         (st_pass),
        .fail_o         (st_fail),
        .monitor_flag_o (st_flag)
    );

    pss_defaults #(
        .NSW (NSW)
    ) u_defaults (
        .sw_in_seq_i                   (sw_in_seq_i),
        .fuse_sync_mode_i              (fuse_sync_mode_i),
        .fuse_sync_output_enable_i     (fuse_sync_output_enable_i),
        .fuse_spread_spectrum_enable_i (fuse_spread_spectrum_enable_i),
        .fuse_switch_mode_i            (fuse_switch_mode_i),
        .switcher_run_mode_o           (mode_dflt)
    );

    // event in low power off is refused on a load error
    function lpm_flag_blocked;
        input dummy;
        lpm_flag_blocked = low_power_off_select_o | trim_load_error_o | fuse_load_error_o;
    endfunction

    // =====================================================
    // main state machine
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r                <= ST_LOAD;
            state_o                <= ST_LOAD;
            slot_r                 <= 2'd0;
            step_cnt_r             <= 5'd0;
            pwrup_done_r           <= 1'b0;
            fuse_load_o            <= 1'b0;
            mirror_to_func_o       <= 1'b0;
            trim_load_error_o      <= 1'b0;
            fuse_load_error_o      <= 1'b0;
            selftest_error_o       <= 1'b0;
            monitor_test_flag_o    <= 1'b0;
            run_test_o             <= 1'b0;
            backup_supply_en_o     <= 1'b0;
            backup_supply_cfg_o    <= 1'b0;
            low_power_off_select_o <= 1'b0;
            mirror_access_o        <= 1'b0;
            func_access_o          <= 1'b0;
            fail_safe_o            <= 1'b0;
            sw_enable_o            <= {NSW{1'b0}};
            ldo_enable_o           <= {NLDO{1'b0}};
            host_reset_out_o       <= 1'b0;
            switcher_run_voltage_o <= {8*NSW{1'b0}};
            linear_run_voltage_o   <= {4*NLDO{1'b0}};
            aux_switcher_voltage_o <= 5'h00;
            switcher_run_mode_o    <= {2*NSW{1'b0}};
            linear_run_enable_o    <= {NLDO{1'b0}};
        end else begin
            run_test_o          <= st_run;
            monitor_test_flag_o <= st_flag;
            if (uv_crossing_i)
                low_power_off_select_o <= 1'b0;
            else if (lpm_set_i && state_r == ST_RUN)
                low_power_off_select_o <= lpm_value_i;
            mirror_access_o <= (state_r == ST_QPU) && io_supply_ok_i;
            func_access_o   <= (state_r == ST_RUN);
            case (state_r)
                ST_LOAD: begin
                    if (core_digital_ldo_ok_i && core_analog_ldo_ok_i && !load_done_i) begin
                        fuse_load_o      <= 1'b1;
                        mirror_to_func_o <= fuse_select_pin_i;
                    end
                    if (fuse_load_o && load_done_i) begin
                        fuse_load_o       <= 1'b0;
                        trim_load_error_o <= !trim_crc_ok_i;
                        fuse_load_error_o <= !fuse_crc_ok_i;
                        if (trim_crc_ok_i && fuse_crc_ok_i) begin
                            backup_supply_en_o  <= 1'b1;
                            backup_supply_cfg_o <= fuse_backup_cfg_i;
                        end
                        state_r <= ST_LPOFF;
                    end
                end
                ST_LPOFF: begin
                    if (low_power_off_select_o && !powerup_event_i)
                        state_r <= ST_QPU;
                    else if (powerup_event_i && !lpm_flag_blocked(1'b0))
                        state_r <= ST_TEST;
                    // otherwise stays: refusal or plain wait
                end
                ST_TEST: begin
                    if (st_pass)
                        state_r <= ST_QPU;
                    else if (st_fail) begin
                        selftest_error_o <= 1'b1;
                        state_r          <= ST_FAIL;
                    end
                end
                ST_QPU: begin
                    if (powerup_event_i && !any_error) begin
                        switcher_run_voltage_o <= fuse_switcher_voltage_i;
                        linear_run_voltage_o   <= fuse_linear_voltage_i;
                        aux_switcher_voltage_o <= fuse_aux_voltage_i;
                        switcher_run_mode_o    <= mode_dflt;
                        linear_run_enable_o    <= ldo_in_seq_i;
                        slot_r                 <= 2'd0;
                        step_cnt_r             <= 5'd0;
                        pwrup_done_r           <= 1'b0;
                        state_r                <= ST_PWRUP;
                    end
                end
                ST_PWRUP, ST_RUN: begin
                    if (!pwrup_done_r) begin
                        if (step_cnt_r == `PSS_STEP_CYC - 1) begin
                            step_cnt_r <= 5'd0;
                            for (k = 0; k < NSW; k = k + 1)
                                if (sw_in_seq_i[k] && sw_slot_i[2*k +: 2] == slot_r)
                                    sw_enable_o[k] <= 1'b1;
                            for (k = 0; k < NLDO; k = k + 1)
                                if (ldo_in_seq_i[k] && ldo_slot_i[2*k +: 2] == slot_r)
                                    ldo_enable_o[k] <= 1'b1;
                            if (reset_slot_i == slot_r) begin
                                host_reset_out_o <= 1'b1;
                                state_r          <= ST_RUN;
                            end
                            if (slot_r == NSTEP - 1)
                                pwrup_done_r <= 1'b1;
                            else
                                slot_r <= slot_r + 2'd1;
                        end else begin
                            step_cnt_r <= step_cnt_r + 5'd1;
                        end
                    end
                    if (state_r == ST_RUN && host_wr_i) begin
                        switcher_run_voltage_o <= host_sw_voltage_i;
                        linear_run_voltage_o   <= host_ldo_voltage_i;
                        linear_run_enable_o    <= host_ldo_enable_i;
                    end
                end
                ST_FAIL: fail_safe_o <= 1'b1;
                default: state_r <= ST_LOAD;
            endcase
            state_o <= state_r;
        end
    end
endmodule
`default_nettype wire

//--- verif/pss_checker.sv
// Purpose: concurrent checks on the startup state machine ports
// Assumes: state codes 1 lpoff, 4 pwrup, 5 run, 6 failsafe
// Notes: bound into every pss_startup instance
`timescale 1ns/1ps
`default_nettype none
module pss_checker #(
    parameter NSW  = 2,
    parameter NLDO = 1
) (
    input wire logic            clk_sys_i,
    input wire logic            resetn_i,
    input wire logic            load_done_i,
    input wire logic            trim_crc_ok_i,
    input wire logic            fuse_crc_ok_i,
    input wire logic [NLDO-1:0] ldo_in_seq_i,
    input wire logic [2:0]      state_o,
    input wire logic            fuse_load_o,
    input wire logic            trim_load_error_o,
    input wire logic            fuse_load_error_o,
    input wire logic            low_power_off_select_o,
    input wire logic            fail_safe_o,
    input wire logic [NSW-1:0]  sw_enable_o,
    input wire logic            host_reset_out_o,
    input wire logic [NLDO-1:0] linear_run_enable_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    // ==========================================================
    // load, release, power up and fail safe steps
    sequence load_end_s;
        fuse_load_o && load_done_i;
    endsequence
    sequence release_s;
        $rose(host_reset_out_o);
    endsequence
    trim_err_a: assert property (load_end_s ##0 !trim_crc_ok_i |-> ##[1:2] trim_load_error_o)
        else $error("trim load error flag missing");
    fuse_err_a: assert property (load_end_s ##0 !fuse_crc_ok_i |-> ##[1:2] fuse_load_error_o)
        else $error("fuse load error flag missing");
    lpoff_refuse_a: assert property (state_o == 3'h1 && !low_power_off_select_o
        && (trim_load_error_o || fuse_load_error_o) |=> state_o == 3'h1) else $error("left lpoff on error");
    run_entry_a: assert property (release_s |-> ##[0:2] state_o == 3'h5)
        else $error("host release without run state");
    reset_hold_a: assert property (host_reset_out_o |=> host_reset_out_o)
        else $error("host reset dropped in run");
    en_phase_a: assert property ($rose(|sw_enable_o) |-> state_o == 3'h4 || state_o == 3'h5)
        else $error("switcher enabled outside power up");
    ldo_dflt_a: assert property (state_o == 3'h4 |-> linear_run_enable_o == ldo_in_seq_i)
        else $error("linear enable default wrong");
    fs_state_a: assert property ($rose(fail_safe_o) |-> ##[0:2] state_o == 3'h6)
        else $error("fail safe without its state");
    fs_sticky_a: assert property (fail_safe_o |=> fail_safe_o)
        else $error("fail safe released");
endmodule
bind pss_startup pss_checker #(.NSW(NSW), .NLDO(NLDO)) i_pss_checker (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .load_done_i(load_done_i), .trim_crc_ok_i(trim_crc_ok_i),
    .fuse_crc_ok_i(fuse_crc_ok_i), .ldo_in_seq_i(ldo_in_seq_i), .state_o(state_o), .fuse_load_o(fuse_load_o),
    .trim_load_error_o(trim_load_error_o), .fuse_load_error_o(fuse_load_error_o), .fail_safe_o(fail_safe_o),
    .low_power_off_select_o(low_power_off_select_o), .sw_enable_o(sw_enable_o),
    .host_reset_out_o(host_reset_out_o), .linear_run_enable_o(linear_run_enable_o));
`default_nettype wire

//--- verif/pss_host_model.sv
// Purpose: host controller stand-in on the reset line and run writes
// Assumes: one write strobe cycle carries all values
// Notes: written values are arbitrary test patterns
`timescale 1ns/1ps
`default_nettype none
module pss_host_model #(
    parameter              NSW    = 2,
    parameter              NLDO   = 1,
    parameter [8*NSW-1:0]  WR_SW  = 16'ha55a,
    parameter [4*NLDO-1:0] WR_LDO = 4'h6
) (
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    input  wire logic              host_reset_out_i,
    output var  logic              host_wr_o,
    output var  logic              lpm_set_o,
    output wire logic [8*NSW-1:0]  host_sw_voltage_o,
    output wire logic [4*NLDO-1:0] host_ldo_voltage_o,
    output wire logic [NLDO-1:0]   host_ldo_enable_o
);
    reg [2:0] boot_cnt_r;
    assign host_sw_voltage_o  = WR_SW;
    assign host_ldo_voltage_o = WR_LDO;
    assign host_ldo_enable_o  = {NLDO{1'h1}};
    // boots only after release, then programs once
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boot_cnt_r <= 3'h0;
            host_wr_o  <= 1'h0;
            lpm_set_o  <= 1'h0;
        end else begin
            host_wr_o <= (boot_cnt_r == 3'h4);
            lpm_set_o <= (boot_cnt_r == 3'h4);
            if (host_reset_out_i && boot_cnt_r != 3'h7)
                boot_cnt_r <= boot_cnt_r + 3'h1;
        end
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for the startup state machine
// Assumes: retry gap shortened to 20 cycles
// Notes: each scenario starts from a fresh reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam [15:0] WR_SW  = 16'ha55a;
    localparam [3:0]  WR_LDO = 4'h6;
    reg         clk_sys_i, resetn_i = 1'h0, ldo_ok = 1'h0, fsel = 1'h1, ld = 1'h0, tok = 1'h1, fok = 1'h1;
    reg         uv = 1'h0, ev = 1'h0, td = 1'h0, cok = 1'h1, mon = 1'h1, sync = 1'h0, syo = 1'h0, fss = 1'h0;
    reg         ldoseq = 1'h1, io = 1'h1, bg = 1'h1;
    reg  [1:0]  swseq = 2'h3, swm = 2'h0, ldoslot = 2'h3, rslot = 2'h2;
    reg  [3:0]  swslot = 4'h4, flv = 4'h9;
    reg  [15:0] fsv = 16'hc35a;
    reg  [4:0]  fav = 5'h15;
    wire [2:0]  state;
    wire        fld, m2f, terr, ferr, serr, mflag, rtest, bken, lpsel, macc, fsafe, ldoen, hrst, ldorun;
    wire        hwr, lset, hle, bkcfg, fac;
    wire [1:0]  swen;
    wire [15:0] swv, hsv;
    wire [3:0]  ldv, swmode, hlv;
    wire [4:0]  auxv;
    integer     n_errors = 0;
    integer     compares = 0;
    pss_startup #(.NSW(2), .NLDO(1), .NSTEP(4), .RETRY_CYC(20)) i_pss_startup (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .core_digital_ldo_ok_i(ldo_ok),
        .core_analog_ldo_ok_i(ldo_ok), .fuse_select_pin_i(fsel), .load_done_i(ld), .trim_crc_ok_i(tok),
        .fuse_crc_ok_i(fok), .uv_crossing_i(uv), .lpm_set_i(lset), .lpm_value_i(1'h1), .powerup_event_i(ev),
        .io_supply_ok_i(io), .test_done_i(td), .clk_ok_i(cok), .bandgap_ok_i(bg), .mirror_crc_ok_i(1'h1),
        .monitor_ok_i(mon), .sw_in_seq_i(swseq), .ldo_in_seq_i(ldoseq), .sw_slot_i(swslot),
        .ldo_slot_i(ldoslot), .reset_slot_i(rslot), .fuse_sync_mode_i(sync), .fuse_sync_output_enable_i(syo),
        .fuse_spread_spectrum_enable_i(fss), .fuse_switch_mode_i(swm), .fuse_switcher_voltage_i(fsv),
        .fuse_linear_voltage_i(flv), .fuse_aux_voltage_i(fav), .fuse_backup_cfg_i(fsel), .host_wr_i(hwr),
        .host_sw_voltage_i(hsv), .host_ldo_voltage_i(hlv), .host_ldo_enable_i(hle), .state_o(state),
        .fuse_load_o(fld), .mirror_to_func_o(m2f), .trim_load_error_o(terr), .fuse_load_error_o(ferr),
        .selftest_error_o(serr), .monitor_test_flag_o(mflag), .run_test_o(rtest), .backup_supply_en_o(bken),
        .backup_supply_cfg_o(bkcfg), .low_power_off_select_o(lpsel), .mirror_access_o(macc), .func_access_o(fac),
        .fail_safe_o(fsafe), .sw_enable_o(swen), .ldo_enable_o(ldoen), .host_reset_out_o(hrst),
        .switcher_run_voltage_o(swv), .linear_run_voltage_o(ldv), .aux_switcher_voltage_o(auxv),
        .switcher_run_mode_o(swmode), .linear_run_enable_o(ldorun));
    pss_host_model #(.NSW(2), .NLDO(1), .WR_SW(WR_SW), .WR_LDO(WR_LDO)) i_pss_host_model (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .host_reset_out_i(hrst), .host_wr_o(hwr),
        .lpm_set_o(lset), .host_sw_voltage_o(hsv), .host_ldo_voltage_o(hlv), .host_ldo_enable_o(hle));
    initial begin
        clk_sys_i = 1'h0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // helpers
    task chk(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task wst(input [2:0] s);
        integer k;
        begin
            for (k = 0; k < 400 && state !== s; k = k + 1) @(negedge clk_sys_i);
            chk(state, s, "state");
        end
    endtask
    function [3:0] emode(input [1:0] seq, input [1:0] m, input f);
        integer i;
        begin
            for (i = 0; i < 2; i = i + 1)
                emode[2*i+:2] = !seq[i] ? 2'h0 : (f || m[i]) ? 2'h1 : 2'h3;
        end
    endfunction
    task boot(input t, input f);
        integer k;
        begin
            resetn_i = 1'h0;
            ldo_ok = 1'h0;
            ld = 1'h0;
            ev = 1'h0;
            tok = t;
            fok = f;
            repeat (6) @(negedge clk_sys_i);
            resetn_i = 1'h1;
            ldo_ok = 1'h1;
            for (k = 0; k < 20 && fld !== 1'h1; k = k + 1) @(negedge clk_sys_i);
            chk(m2f, fsel, "to_func");
            ld = 1'h1;
            repeat (3) @(negedge clk_sys_i);
            chk(terr, !t, "trim_err");
            chk(ferr, !f, "fuse_err");
        end
    endtask
    task attempt(input ok);
        integer k;
        begin
            for (k = 0; k < 60 && rtest !== 1'h1; k = k + 1) @(negedge clk_sys_i);
            chk(rtest, 1'h1, "testing");
            cok = ok;
            td = 1'h1;
            @(negedge clk_sys_i);
            td = 1'h0;
            cok = 1'h1;
            repeat (2) @(negedge clk_sys_i);
        end
    endtask
    // ==========================================================
    // scenarios
    task s_load_err(input t, input f);
        begin
            boot(t, f);
            wst(3'h1);
            ev = 1'h1;
            repeat (10) @(negedge clk_sys_i);
            chk(state, 3'h1, "ignored");
            chk(rtest, 1'h0, "no_test");
        end
    endtask
    task front(input [2:0] c);
        begin
            sync = (c == 3'h0);
            syo = (c == 3'h1);
            fss = (c == 3'h2);
            swm = (c == 3'h3) ? 2'h2 : 2'h0;
            swseq = (c == 3'h4) ? 2'h1 : 2'h3;
            ldoseq = (c != 3'h4);
            fsel = c[0];
            io = (c != 3'h1);
            rslot = 2'h2 - c[0];
            fsv[2:0] = c;
            flv[2:0] = c;
            mon = 1'h1;
            boot(1'h1, 1'h1);
            wst(3'h1);
            chk(bken, 1'h1, "backup");
            chk(bkcfg, fsel, "bk_cfg");
            repeat (5) @(negedge clk_sys_i);
            chk(state, 3'h1, "lp_wait");
            chk(lpsel, 1'h0, "lpm_sel");
            ev = 1'h1;
            wst(3'h2);
            ev = 1'h0;
        end
    endtask
    task s_failsafe;
        begin
            front(3'h3);
            bg = 1'h0;
            repeat (3) attempt(1'h1);
            chk(fsafe, 1'h1, "failsafe");
            wst(3'h6);
        end
    endtask
    task s_power(input [2:0] c, input [1:0] nf);
        integer k;
        begin
            front(c);
            repeat (nf) attempt(1'h0);
            mon = 1'h0;
            attempt(1'h1);
            chk(mflag, 1'h1, "mon_flag");
            chk(serr, 1'h0, "st_err");
            wst(3'h3);
            chk(macc, io, "mirror");
            ev = 1'h1;
            wst(3'h4);
            ev = 1'h0;
            chk(swv, fsv, "sw_volt");
            chk(ldv, flv, "ldo_volt");
            chk(auxv, fav, "aux_volt");
            chk(swmode, emode(swseq, swm, sync || syo || fss), "mode");
            chk(ldorun, ldoseq, "ldo_en");
            for (k = 0; k < 40 && swen === 2'h0; k = k + 1) @(negedge clk_sys_i);
            chk(swen, 2'h1, "first_en");
            for (k = 0; k < 60 && hrst !== 1'h1; k = k + 1) @(negedge clk_sys_i);
            chk(ldoen, 1'h0, "ldo_late");
            wst(3'h5);
            chk(fac, 1'h1, "func_acc");
            repeat (40) @(negedge clk_sys_i);
            chk(swen, swseq, "all_en");
            chk(ldoen, ldoseq, "ldo_on");
            chk(hrst, 1'h1, "released");
            chk(swv, WR_SW, "host_sw");
            chk(ldv, WR_LDO, "host_ldo");
            chk(lpsel, 1'h1, "lpm_set");
            uv = 1'h1;
            @(negedge clk_sys_i);
            uv = 1'h0;
            repeat (2) @(negedge clk_sys_i);
            chk(lpsel, 1'h0, "uv_clr");
        end
    endtask
    task final_report;
        begin
            $display("compares %0d n_errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        s_load_err(1'h0, 1'h1);
        s_load_err(1'h1, 1'h0);
        s_power(3'h3, 2'h2);
        s_power(3'h0, 2'h0);
        s_power(3'h1, 2'h0);
        s_power(3'h2, 2'h0);
        s_power(3'h4, 2'h0);
        s_failsafe;
        final_report;
    end
    // about 700 cycles expected; 40000 leaves wide margin
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        final_report;
    end
endmodule
`default_nettype wire
